// ==== bsw_writer.v ====
`timescale 1ns/1ps
`include "bsw_writer_defines.vh"

// Behaviour
// - status word is written to the message block in ram after completion
// - bit 15 set when a message completes, with or without errors
// - on completion the current time tag is written to the block
// - bit 14 set at message start, cleared at message end
// - time tag stored into the block when bit 14 sets and clears
// - bit 13 records bus used: one for bus b, zero for bus a
// - bit 12 only active while format check enable is one
// - control word format flags compared with following command words
// - format mismatch sets bit 12 of the status word
// - status word lives in ram; host may read and write it
module bsw_writer (
  input  wire        clk,
  input  wire        arst_n,
  input  wire        msg_start,
  input  wire        msg_end,
  input  wire        bus_b,
  input  wire        format_check_enable,
  input  wire        time_tag_32bit,
  input  wire [31:0] time_tag,
  input  wire [15:0] block_base,
  input  wire [15:0] control_word,
  input  wire [15:0] command_word_1,
  input  wire [15:0] command_word_2,
  input  wire [11:0] error_bits,
  input  wire        ram_grant,
  output reg  [15:0] ram_addr,
  output reg  [15:0] ram_wdata,
  output reg         ram_we,
  output reg  [15:0] status_word,
  output reg         writer_busy
);

  localparam [1:0] ST_IDLE   = 2'b00;
  localparam [1:0] ST_STATUS = 2'b01;
  localparam [1:0] ST_TAG_LO = 2'b10;
  localparam [1:0] ST_TAG_HI = 2'b11;

  ////////////////////////////////////////////////////////////////////////////

  function [15:0] word_addr;
    input [15:0] base;
    input [15:0] ofs;
    begin
      word_addr = base + ofs;
    end
  endfunction

  function sa_is_mode;
    input [15:0] cmd;
    reg   [4:0]  sa;
    begin
      sa = cmd[`CMD_SUBADDR_MSB:`CMD_SUBADDR_LSB];
      sa_is_mode = (sa == `CMD_MODE_SA_LO) || (sa == `CMD_MODE_SA_HI);
    end
  endfunction

  // format implied by the command words, laid out like the control flags
  function [2:0] cmd_format;
    input [15:0] cmd1;
    input [15:0] cmd2;
    reg          rtrt;
    begin
      rtrt = !cmd1[`CMD_TR_BIT] && cmd2[`CMD_TR_BIT] && !sa_is_mode(cmd2);
      cmd_format = 3'b000;
      cmd_format[`CW_MODE_BIT] = sa_is_mode(cmd1);
      cmd_format[`CW_RTRT_BIT] = rtrt;
      cmd_format[`CW_BCST_BIT] =
        (cmd1[`CMD_RTADDR_MSB:`CMD_RTADDR_LSB] == `CMD_BCST_ADDR);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [15:0] base_reg;
  reg         bus_reg;
  reg         mismatch_reg;
  reg  [31:0] tag_reg;
  reg         wide_reg;
  reg         pend_end_reg;
  reg  [31:0] pend_tag_reg;
  reg  [11:0] pend_err_reg;

  wire [2:0]  ctl_fmt;
  wire [2:0]  cmd_fmt;
  wire        fmt_differs;
  wire        check_hit;
  wire        is_idle;
  wire        launch_end;
  wire        take_start;
  wire        begin_seq;
  wire [15:0] start_word;
  wire [15:0] end_word;
  wire [15:0] first_addr;
  wire [15:0] first_word;
  wire [15:0] tag_lo_addr;
  wire [15:0] tag_hi_addr;

  ////////////////////////////////////////////////////////////////////////////
  // format check

  assign ctl_fmt = {control_word[`CW_MODE_BIT],
                    control_word[`CW_RTRT_BIT],
                    control_word[`CW_BCST_BIT]};

  // command words decoded into the same bit layout as the control flags
  assign cmd_fmt = cmd_format(command_word_1, command_word_2);

  // flags compared field by field against the command words
  assign fmt_differs = (ctl_fmt != cmd_fmt);

  // enable sampled at start so a mid-message change cannot flag it
  assign check_hit = format_check_enable && fmt_differs;

  ////////////////////////////////////////////////////////////////////////////
  // sequence launch

  assign is_idle = (state_reg == ST_IDLE);

  // an end seen while a write runs waits for the idle state
  assign launch_end = is_idle && pend_end_reg;

  // a queued end goes first; a start while busy is dropped
  assign take_start = is_idle && !pend_end_reg && msg_start;

  assign begin_seq = launch_end || take_start;

  // start word: active flag set, done clear, bus bit from bus_b, lower flags zero
  assign start_word = {1'b0, 1'b1, bus_b, 1'b0, 12'h000};

  // end word: done set, active cleared, mismatch and errors filled in
  assign end_word = {1'b1, 1'b0, bus_reg, mismatch_reg,
                     pend_err_reg};

  // the end word goes to the block saved at start, not the current base
  assign first_addr = launch_end ? word_addr(base_reg, `OFS_STATUS) :
                                   word_addr(block_base, `OFS_STATUS);

  assign first_word = launch_end ? end_word : start_word;

  // tag words paired low first at fixed offsets in the block
  assign tag_lo_addr = word_addr(base_reg, `OFS_TAG_LO);
  assign tag_hi_addr = word_addr(base_reg, `OFS_TAG_HI);

  ////////////////////////////////////////////////////////////////////////////
  // write sequence: status word, tag low, then tag high if wide

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (begin_seq) begin
          state_next = ST_STATUS;
        end
      end
      // each word waits in its state until the ram grants it
      ST_STATUS: begin
        if (ram_grant) begin
          state_next = ST_TAG_LO;
        end
      end
      ST_TAG_LO: begin
        if (ram_grant) begin
          state_next = wide_reg ? ST_TAG_HI : ST_IDLE;
        end
      end
      ST_TAG_HI: begin
        if (ram_grant) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // message context
  // limitation: only one end is queued; a second one before launch
  // overwrites the first snapshot

  // end event captured even when it lands in a busy cycle;
  // an end in the launch cycle re-arms the flag, so the set wins
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_end_reg <= 1'b0;
      pend_tag_reg <= 32'h00000000;
      pend_err_reg <= 12'h000;
    end else begin
      if (msg_end) begin
        pend_end_reg <= 1'b1;
        pend_tag_reg <= time_tag;
        pend_err_reg <= error_bits;
      end else if (launch_end) begin
        pend_end_reg <= 1'b0;
      end
    end
  end

  // start fields held until the end word is built
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      base_reg     <= 16'h0000;
      bus_reg      <= 1'b0;
      mismatch_reg <= 1'b0;
    end else begin
      if (take_start) begin
        base_reg     <= block_base;
        bus_reg      <= bus_b;
        mismatch_reg <= check_hit;
      end
    end
  end

  // tag snapshot and word count for the running sequence
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tag_reg  <= 32'h00000000;
      wide_reg <= 1'b0;
    end else begin
      if (launch_end) begin
        tag_reg  <= pend_tag_reg;
        wide_reg <= time_tag_32bit;
      end else if (take_start) begin
        tag_reg  <= time_tag;
        wide_reg <= time_tag_32bit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // busy follows the next state so it rises with the first write
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      writer_busy <= 1'b0;
    end else begin
      writer_busy <= (state_next != ST_IDLE);
    end
  end

  // whole word rewritten: host edits to it are overwritten
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_word <= `BSW_RESET;
    end else if (begin_seq) begin
      status_word <= first_word;
    end
  end

  // ram write port; each word is held until the arbiter grants it
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ram_addr  <= 16'h0000;
      ram_wdata <= 16'h0000;
      ram_we    <= 1'b0;
    end else begin
      case (state_next)
        ST_STATUS: begin
          ram_we <= 1'b1;
          if (is_idle) begin
            ram_addr  <= first_addr;
            ram_wdata <= first_word;
          end
        end
        ST_TAG_LO: begin
          ram_we    <= 1'b1;
          ram_addr  <= tag_lo_addr;
          ram_wdata <= tag_reg[15:0];
        end
        ST_TAG_HI: begin
          ram_we    <= 1'b1;
          ram_addr  <= tag_hi_addr;
          ram_wdata <= tag_reg[31:16];
        end
        default: begin
          ram_we <= 1'b0;
        end
      endcase
    end
  end

endmodule // bsw_writer

// ==== bsw_writer_defines.vh ====
`ifndef BSW_WRITER_DEFINES_VH
`define BSW_WRITER_DEFINES_VH

// status word field positions
`define BSW_DONE_BIT      15
`define BSW_ACTIVE_BIT    14
`define BSW_BUS_BIT       13
`define BSW_MISMATCH_BIT  12
`define BSW_LOW_MSB       11
`define BSW_RESET         16'h0000

// format flags in the control word
`define CW_MODE_BIT       2
`define CW_RTRT_BIT       1
`define CW_BCST_BIT       0

// command word fields
`define CMD_RTADDR_MSB    15
`define CMD_RTADDR_LSB    11
`define CMD_TR_BIT        10
`define CMD_SUBADDR_MSB   9
`define CMD_SUBADDR_LSB   5
`define CMD_BCST_ADDR     5'h1F
`define CMD_MODE_SA_LO    5'h00
`define CMD_MODE_SA_HI    5'h1F

// word offsets inside the message control / status block
`define OFS_STATUS        16'h0001
`define OFS_TAG_LO        16'h0002
`define OFS_TAG_HI        16'h0003

`endif

// ==== bsw_writer_checker.sv ====
`timescale 1ns/1ps
module bsw_writer_checker (
  input wire        clk,
  input wire        arst_n,
  input wire        msg_start,
  input wire        msg_end,
  input wire        bus_b,
  input wire        format_check_enable,
  input wire [31:0] time_tag,
  input wire [15:0] block_base,
  input wire        ram_grant,
  input wire [15:0] ram_addr,
  input wire [15:0] ram_wdata,
  input wire        ram_we,
  input wire [15:0] status_word,
  input wire        writer_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  reg [15:0] tag_reg;
  always @(posedge clk)
    if (msg_start && !writer_busy)
      tag_reg <= time_tag[15:0];
  sequence s_take; msg_start && !writer_busy; endsequence
  sequence s_first; s_take ##1 ram_we && ram_grant; endsequence
  AST_START_ADDR: assert property (s_take |=> ram_we &&
    ram_addr == $past(block_base) + 16'h0001) else $error("start addr");
  AST_START_DATA: assert property (s_take |=>
    ram_wdata == {2'b01, $past(bus_b), 13'h0000}) else $error("start word");
  AST_TAG_LO: assert property (s_first |=> ram_we &&
    ram_wdata == tag_reg) else $error("start tag");
  AST_HOLD: assert property (ram_we && !ram_grant |=>
    ram_we && $stable(ram_addr) && $stable(ram_wdata)) else $error("hold");
  AST_IDLE: assert property (!writer_busy |-> !ram_we)
    else $error("write while idle");
  // status_word takes the start word the next cycle whatever the grant; the late window reaches the end word
  AST_MM_OFF: assert property ((s_take and !format_check_enable) |->
    ##5 !status_word[12] [*6]) else $error("mismatch flag");
  AST_DONE: assert property (msg_end |-> ##[1:60] status_word[15])
    else $error("no done word");
  AST_DONE_CLR: assert property (status_word[15] |-> !status_word[14])
    else $error("active at done");
endmodule // bsw_writer_checker
bind bsw_writer bsw_writer_checker u_bsw_writer_checker (.clk, .arst_n,
  .msg_start, .msg_end, .bus_b, .format_check_enable, .time_tag, .block_base,
  .ram_grant, .ram_addr, .ram_wdata, .ram_we, .status_word, .writer_busy);

// ==== ram_partner.sv ====
`timescale 1ns/1ps
module ram_partner (
  input  wire clk,
  input  wire slow,
  output reg  ram_grant
);
  reg [1:0] cnt_reg = 2'h0;
  always @(posedge clk)
    cnt_reg <= cnt_reg + 2'h1;
  // a busy ram grants one cycle in four, so every word must be held
  always @*
    ram_grant = !slow || cnt_reg == 2'h3;
endmodule // ram_partner

// ==== bsw_writer_tb.sv ====
`timescale 1ns/1ps
module bsw_writer_tb;
  reg         clk = 1'b0, arst_n = 1'b0, msg_start, msg_end, bus_b, slow;
  reg         format_check_enable, time_tag_32bit;
  reg  [31:0] time_tag;
  reg  [15:0] block_base, control_word, command_word_1, command_word_2;
  reg  [11:0] error_bits;
  wire        ram_grant, ram_we, writer_busy;
  wire [15:0] ram_addr, ram_wdata, status_word;
  reg  [31:0] exp_q[$];
  integer     seed = 78, mismatches = 0, checked = 0, i, n;
  bsw_writer u_bsw_writer (.clk, .arst_n, .msg_start, .msg_end, .bus_b,
    .format_check_enable, .time_tag_32bit, .time_tag, .block_base,
    .control_word, .command_word_1, .command_word_2, .error_bits,
    .ram_grant, .ram_addr, .ram_wdata, .ram_we, .status_word, .writer_busy);
  ram_partner u_ram_partner (.clk, .slow, .ram_grant);
  always #5 clk = ~clk;
  task check(input string what, input [31:0] seen, input [31:0] want);
    checked = checked + 1;
    if (seen !== want) begin
      mismatches = mismatches + 1;
      $display("[ERR] %s exp %h seen %h", what, want, seen);
    end
  endtask
  task print_verdict;
    if (mismatches == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task note(input [15:0] a, input [15:0] d);
    exp_q.push_back({a, d});
  endtask
  function [2:0] fmt(input [15:0] c1, input [15:0] c2);
    fmt = {c1[9:5] == 5'h00 || c1[9:5] == 5'h1F,
      !c1[10] && c2[10] && c2[9:5] != 5'h00 && c2[9:5] != 5'h1F,
      c1[15:11] == 5'h1F};
  endfunction
  task wait_idle;
    #1;
    for (n = 0; n < 80 && (writer_busy !== 1'b0 || exp_q.size()); n++)
      @(posedge clk);
    if (n == 80) begin
      mismatches = mismatches + 1;
      print_verdict;
    end
  endtask
  always @(posedge clk)
    if (ram_we === 1'b1 && ram_grant === 1'b1)
      check("ram write", {ram_addr, ram_wdata},
        exp_q.size() ? exp_q.pop_front() : '1);
  task run_msg(input [4:0] k);
    reg [15:0] c1, c2, b0;
    reg [31:0] t, t2;
    reg [11:0] e;
    reg [2:0]  ctl;
    reg        b, mm;
    begin
      {c1, c2, b0, e, b} = {$random(seed), $random(seed)};
      {t, t2} = {$random(seed), $random(seed)};
      ctl = fmt(c1, c2) ^ (k[3] ? 3'h1 << k[1:0] : 3'h0);
      mm = k[0] && ctl != fmt(c1, c2);
      @(posedge clk);
      format_check_enable <= k[0];
      time_tag_32bit <= k[1];
      slow <= k[2];
      msg_start <= 1'b1;
      bus_b <= b;
      block_base <= b0;
      control_word <= {13'h0000, ctl};
      command_word_1 <= c1;
      command_word_2 <= c2;
      time_tag <= t;
      note(b0 + 16'h0001, {2'b01, b, 13'h0000});
      note(b0 + 16'h0002, t[15:0]);
      if (k[1]) note(b0 + 16'h0003, t[31:16]);
      @(posedge clk);
      if (k[4]) begin
        msg_start <= 1'b1; // ignored: the writer is still busy
      end else begin
        msg_start <= 1'b0;
        wait_idle;
        check("status word", status_word, {2'b01, b, 13'h0000});
        @(posedge clk);
      end
      msg_end <= 1'b1;
      error_bits <= e;
      time_tag <= t2;
      note(b0 + 16'h0001, {2'b10, b, mm, e});
      note(b0 + 16'h0002, t2[15:0]);
      if (k[1]) note(b0 + 16'h0003, t2[31:16]);
      @(posedge clk);
      msg_start <= 1'b0;
      msg_end <= 1'b0;
      wait_idle;
      check("status word", status_word, {2'b10, b, mm, e});
    end
  endtask
  initial begin
    {msg_start, msg_end, bus_b, slow, format_check_enable, time_tag_32bit,
      time_tag, block_base, control_word, command_word_1, command_word_2,
      error_bits} = '0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    for (i = 0; i < 32; i = i + 1)
      run_msg(i[4:0]);
    print_verdict;
  end
endmodule // bsw_writer_tb
